//--- include/reset_clock_map.vh
`ifndef RESET_CLOCK_MAP_VH
`define RESET_CLOCK_MAP_VH

// reset output lags the synchronised reset release by this many cpu_clock_output periods
`define RST_RELEASE_CPU_CLOCK_OUTPUT    2
// mode pin is sampled again this many cpu_clock_output periods after reset release
`define MODE_SAMPLE_CPU_CLOCK_OUTPUT    4
// test pin is resampled every this many cpu_clock_output periods during a wait
`define TEST_POLL_CPU_CLOCK_OUTPUT      5
// first fetch after reset release, in half cpu_clock_output periods (6.5 periods)
`define FETCH_DELAY_HALF      13
// least reset length in cpu_clock_output periods for correct initialisation
`define RESET_MIN_CPU_CLOCK_OUTPUT      4

`define MODE_COMPATIBLE       1'b0
`define MODE_ENHANCED         1'b1

`endif

//--- core/sync_bit.v
`timescale 1ns/100ps

// two-stage synchroniser; the first stage feeds only the second
module sync_bit
#(
    parameter RESET_VAL = 1'b0
)
(
    input  wire clk,
    input  wire rst_n,
    input  wire din,
    output wire dout
);

reg meta_ff;
reg sync_ff;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        meta_ff <= RESET_VAL;
        sync_ff <= RESET_VAL;
    end
    else
    begin
        meta_ff <= din;
        sync_ff <= meta_ff;
    end
end

assign dout = sync_ff;

endmodule

//--- core/reset_clock_mode_select.v
`timescale 1ns/100ps
`include "reset_clock_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// RL1 - reset output active high, clock aligned, length tracks reset input
// RL2 - reset output drops two cpu_clock_output periods after reset input rises
// RL3 - reset output driven during bus hold: low in hold, high in reset
// RL4 - reset output looped to mode pin yields enhanced mode
// RL5 - processor clock is input clock divided by two
// RL6 - cpu_clock_output 50% duty, toggling through reset and bus hold
// RL7 - active reset input aborts activity, clears logic, stays dormant
// RL8 - reset input taken asynchronously and synchronised before use
// RL9 - first fetch about six and a half clocks after reset release
// RL10 - board holds reset low with stable clock over four clocks
// RL11 - enhanced only if pin high at release, low four clkouts later
// RL12 - mode pin has weak pull-up, reads high when undriven
// RL13 - board asserts reset at power-up so mode pin becomes input
// RL14 - compatible wait suspends while test high, resampled every five clocks
// RL15 - interrupts still serviced while suspended on test
// RL16 - enhanced mode: pin is active-high coprocessor busy input
// RL17 - mode held unchanged until the next reset input assertion
module reset_clock_mode_select
(
    input  wire REF_CLK,
    input  wire RST_N,
    input  wire reset_in_n,
    input  wire TEST_BUSY_IN,
    output wire TEST_BUSY_PULLUP,
    input  wire BUS_HOLD,
    input  wire WAIT_START,
    input  wire INT_PENDING,
    input  wire FP_CHECK,
    output wire cpu_clock_output,
    output wire SYS_RESET,
    output wire CORE_RESET,
    output wire FETCH_ENABLE,
    output wire ENHANCED_MODE,
    output wire WAIT_STALL,
    output wire WAIT_INT_TAKE,
    output wire COPROC_BUSY
);

localparam ST_RESET   = 2'b00;
localparam ST_RELEASE = 2'b01;
localparam ST_MODE    = 2'b10;
localparam ST_RUN     = 2'b11;

reg        clk_div_ff;
reg  [1:0] state_ff;
reg  [1:0] nxt_state;
reg  [3:0] count_ff;
reg  [3:0] nxt_count;
reg        sys_reset_ff;
reg        mode_high_ff;
reg        enhanced_ff;
reg  [3:0] fetch_ff;
reg        fetch_en_ff;
reg        waiting_ff;
reg  [2:0] poll_ff;
reg        busy_ff;

wire res_sync_n;
wire test_sync;
wire tick;

//////////////////////////////////////////////////////////////////////////////
// asynchronous reset pin and mode pin both cross into REF_CLK

sync_bit #(.RESET_VAL(1'b0)) u_res_sync  // RL8
(
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .din   (reset_in_n),
    .dout  (res_sync_n)
);

sync_bit #(.RESET_VAL(1'b1)) u_test_sync
(
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .din   (TEST_BUSY_IN),
    .dout  (test_sync)
);

// the pad pull-up is requested here; the pad itself does the pulling
assign TEST_BUSY_PULLUP = 1'b1; // RL12

//////////////////////////////////////////////////////////////////////////////
// divide by two: free running once RST_N is high, never gated by reset_in_n or hold

always @(posedge REF_CLK or negedge RST_N)
begin
    if (!RST_N)
        clk_div_ff <= 1'b0;
    else
        clk_div_ff <= ~clk_div_ff; // RL5 RL6
end

assign cpu_clock_output = clk_div_ff;
// one REF_CLK cycle per cpu_clock_output period, at the cpu_clock_output rising edge
assign tick = ~clk_div_ff;

//////////////////////////////////////////////////////////////////////////////
// reset sequencer, stepping on cpu_clock_output periods

always @*
begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    if (!res_sync_n)
    begin
        nxt_state = ST_RESET; // RL7
        nxt_count = 4'h0;
    end
    else if (tick)
    begin
        case (state_ff)
            ST_RESET:
            begin
                nxt_state = ST_RELEASE;
                nxt_count = 4'h1;
            end
            ST_RELEASE:
            begin
                if (count_ff == `RST_RELEASE_CPU_CLOCK_OUTPUT) // RL2
                    nxt_state = ST_MODE;
                nxt_count = count_ff + 4'h1;
            end
            ST_MODE:
            begin
                if (count_ff == `MODE_SAMPLE_CPU_CLOCK_OUTPUT) // RL11
                    nxt_state = ST_RUN;
                else
                    nxt_count = count_ff + 4'h1;
            end
            default:
                nxt_state = ST_RUN;
        endcase
    end
end

always @(posedge REF_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        state_ff     <= ST_RESET;
        count_ff     <= 4'h0;
        sys_reset_ff <= 1'b1;
        mode_high_ff <= 1'b0;
        enhanced_ff  <= `MODE_COMPATIBLE;
    end
    else
    begin
        state_ff <= nxt_state;
        count_ff <= nxt_count;
        // registered so the output stays clock aligned
        sys_reset_ff <= (nxt_state == ST_RESET) ||
                        (nxt_state == ST_RELEASE); // RL1 RL2 RL3
        if (tick && state_ff == ST_RESET && res_sync_n)
            mode_high_ff <= test_sync; // RL11
        if (!res_sync_n)
            enhanced_ff <= `MODE_COMPATIBLE;
        else if (tick && state_ff == ST_MODE &&
                 count_ff == `MODE_SAMPLE_CPU_CLOCK_OUTPUT)
            // loopback of the reset output gives high then low
            enhanced_ff <= mode_high_ff & ~test_sync; // RL4 RL11 RL17
    end
end

// hold does not affect reset: low in hold, high in reset
assign SYS_RESET     = sys_reset_ff; // RL3
assign CORE_RESET    = sys_reset_ff; // RL7
assign ENHANCED_MODE = enhanced_ff;

//////////////////////////////////////////////////////////////////////////////
// first fetch counted in half cpu_clock_output periods from synced release

always @(posedge REF_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        fetch_ff    <= 4'h0;
        fetch_en_ff <= 1'b0;
    end
    else if (!res_sync_n)
    begin
        fetch_ff    <= 4'h0;
        fetch_en_ff <= 1'b0;
    end
    else if (!fetch_en_ff)
    begin
        if (fetch_ff == `FETCH_DELAY_HALF - 1)
            fetch_en_ff <= 1'b1; // RL9
        fetch_ff <= fetch_ff + 4'h1;
    end
end

assign FETCH_ENABLE = fetch_en_ff;

//////////////////////////////////////////////////////////////////////////////
// compatible mode wait on test; enhanced mode busy

always @(posedge REF_CLK or negedge RST_N)
begin
    if (!RST_N)
    begin
        waiting_ff <= 1'b0;
        poll_ff    <= 3'h0;
        busy_ff    <= 1'b0;
    end
    else if (!res_sync_n)
    begin
        waiting_ff <= 1'b0;
        poll_ff    <= 3'h0;
        busy_ff    <= 1'b0;
    end
    else
    begin
        if (!enhanced_ff && WAIT_START && !waiting_ff)
        begin
            waiting_ff <= test_sync; // RL14
            poll_ff    <= 3'h0;
        end
        else if (waiting_ff && tick)
        begin
            if (poll_ff == `TEST_POLL_CPU_CLOCK_OUTPUT - 1)
            begin
                poll_ff <= 3'h0;
                // the input is only looked at on poll slots
                waiting_ff <= test_sync; // RL14
            end
            else
                poll_ff <= poll_ff + 3'h1;
        end
        if (enhanced_ff && FP_CHECK)
            busy_ff <= test_sync; // RL16
    end
end

assign WAIT_STALL    = waiting_ff;
assign WAIT_INT_TAKE = waiting_ff & INT_PENDING; // RL15
assign COPROC_BUSY   = busy_ff;

endmodule

//--- verif/rcms_assertions.sv
`timescale 1ns/100ps
module rcms_chk
(
    input wire REF_CLK,
    input wire RST_N,
    input wire reset_in_n,
    input wire INT_PENDING,
    input wire cpu_clock_output,
    input wire SYS_RESET,
    input wire CORE_RESET,
    input wire FETCH_ENABLE,
    input wire ENHANCED_MODE,
    input wire WAIT_STALL,
    input wire WAIT_INT_TAKE
);
    reg [5:0] hi_ff;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////
    // mode may only settle in the first cycles after a release
    always @(posedge REF_CLK or negedge RST_N)
        if (!RST_N)
            hi_ff <= 6'h0;
        else if (!reset_in_n)
            hi_ff <= 6'h0;
        else if (hi_ff != 6'h3f)
            hi_ff <= hi_ff + 6'h1;
    ////////////////////////////////////////////////////////////////////////
    a_clk_toggles: assert property ($past(RST_N) |->
        cpu_clock_output != $past(cpu_clock_output)) else $error("clk stuck");
    a_rst_follows: assert property (!reset_in_n [*3] |=>
        SYS_RESET && CORE_RESET) else $error("reset out not raised");
    a_rst_release: assert property ($rose(reset_in_n) |->
        SYS_RESET [*5]) else $error("reset out dropped early");
    a_fetch_delay: assert property ($rose(reset_in_n) |->
        !FETCH_ENABLE [*8] ##[1:12] FETCH_ENABLE) else $error("fetch time");
    a_fetch_quiet: assert property (SYS_RESET |-> !FETCH_ENABLE)
        else $error("fetch during reset");
    a_mode_fixed: assert property (hi_ff == 6'h3f |->
        $stable(ENHANCED_MODE)) else $error("mode changed");
    a_int_served: assert property (WAIT_INT_TAKE ==
        (WAIT_STALL && INT_PENDING)) else $error("int take wrong");
    a_stall_compat: assert property (WAIT_STALL |-> !ENHANCED_MODE)
        else $error("stall in enhanced mode");
    cover property ($rose(ENHANCED_MODE));
    cover property ($fell(WAIT_STALL));
    cover property (WAIT_INT_TAKE);
endmodule

bind reset_clock_mode_select rcms_chk chk_u (.REF_CLK, .RST_N, .reset_in_n,
    .INT_PENDING, .cpu_clock_output, .SYS_RESET, .CORE_RESET, .FETCH_ENABLE,
    .ENHANCED_MODE, .WAIT_STALL, .WAIT_INT_TAKE);

//--- verif/board_model.sv
`timescale 1ns/100ps
module board_model
(
    input  wire rel,
    input  wire loop_en,
    input  wire drv_en,
    input  wire drv_val,
    input  wire sys_reset,
    output wire reset_in_n,
    output wire test_pin
);
    // release is async to the core clock; the bench holds it low long
    assign reset_in_n = rel;
    // an undriven pin floats up through the weak pull-up
    assign test_pin = loop_en ? sys_reset : (drv_en ? drv_val : 1'b1);
endmodule

//--- verif/reset_clock_mode_select_tb_top.sv
`timescale 1ns/100ps
module reset_clock_mode_select_tb_top;
    reg     ref_clk = 1'b0, rst_n = 1'b0, rel = 1'b0, last;
    reg     loop_en = 1'b0, drv_en = 1'b0, drv_val = 1'b0, hold = 1'b0;
    reg     wstart = 1'b0, int_p = 1'b0, fp = 1'b0;
    wire    rin_n, pin, pu, clk_o, sys_r, core_r, fetch, enh, stall, take, cpb;
    integer err_total = 0, cmp_count = 0, n;
    board_model brd_u (.rel(rel), .loop_en(loop_en), .drv_en(drv_en),
        .drv_val(drv_val), .sys_reset(sys_r), .reset_in_n(rin_n),
        .test_pin(pin));
    reset_clock_mode_select dut_u (.REF_CLK(ref_clk), .RST_N(rst_n),
        .reset_in_n(rin_n), .TEST_BUSY_IN(pin), .TEST_BUSY_PULLUP(pu),
        .BUS_HOLD(hold), .WAIT_START(wstart), .INT_PENDING(int_p),
        .FP_CHECK(fp), .cpu_clock_output(clk_o), .SYS_RESET(sys_r),
        .CORE_RESET(core_r), .FETCH_ENABLE(fetch), .ENHANCED_MODE(enh),
        .WAIT_STALL(stall), .WAIT_INT_TAKE(take), .COPROC_BUSY(cpb));
    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("MISMATCH %s exp %0h seen %0h", what, exp, got);
        end
    end
    endtask
    task final_report;
    begin
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // sample a little after the edge so design updates have landed
    task tk;
    begin
        @(posedge ref_clk);
        #1;
    end
    endtask
    task pulse(input f);
    begin
        @(posedge ref_clk);
        wstart <= !f;
        fp <= f;
        @(posedge ref_clk);
        wstart <= 1'b0;
        fp <= 1'b0;
    end
    endtask
    task boot(input lp, input en, input v, input em);
    begin
        @(posedge ref_clk);
        {rel, loop_en, drv_en, drv_val, hold} <= {1'b0, lp, en, v, 1'b1};
        repeat (5)
        begin
            tk;
            last = clk_o;
            tk;
            check("cpu_clock_output", clk_o, !last);
        end
        check("reset out", sys_r, 1);
        check("core reset", core_r, 1);
        @(posedge ref_clk);
        rel <= 1'b1;
        hold <= 1'b0;
        n = 0;
        while (sys_r !== 1'b0 && n < 40)
        begin
            tk;
            n = n + 1;
        end
        check("release", n >= 6 && n <= 11, 1);
        while (fetch !== 1'b1 && n < 60)
        begin
            tk;
            n = n + 1;
        end
        check("fetch", n >= 14 && n <= 18, 1);
        repeat (40) tk;
        check("mode", enh, em);
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task test_compat;
    begin
        boot(1'b0, 1'b0, 1'b0, 1'b0);
        check("pullup", pu, 1);
        @(posedge ref_clk);
        drv_en <= 1'b1;
        drv_val <= 1'b1;
        repeat (4) tk;
        pulse(1'b0);
        repeat (24) tk;
        check("stall", stall, 1);
        @(posedge ref_clk);
        int_p <= 1'b1;
        tk;
        check("int take", take, 1);
        @(posedge ref_clk);
        drv_val <= 1'b0;
        int_p <= 1'b0;
        n = 0;
        while (stall !== 1'b0 && n < 40)
        begin
            tk;
            n = n + 1;
        end
        check("resume", n >= 2 && n <= 14, 1);
        $display("test_compat done");
    end
    endtask
    task test_loop;
    begin
        boot(1'b1, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk);
        // loopback off so the coprocessor drive reaches the pin
        {loop_en, drv_en, drv_val} <= 3'h3;
        repeat (4) tk;
        pulse(1'b1);
        repeat (4) tk;
        check("busy", cpb, 1);
        pulse(1'b0);
        repeat (4) tk;
        check("refused", stall, 0);
        check("mode kept", enh, 1);
        @(posedge ref_clk);
        drv_val <= 1'b0;
        repeat (4) tk;
        pulse(1'b1);
        repeat (4) tk;
        check("not busy", cpb, 0);
        $display("test_loop done");
    end
    endtask
    task test_low;
    begin
        boot(1'b0, 1'b1, 1'b0, 1'b0);
        $display("test_low done");
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
        forever #5 ref_clk = !ref_clk;
    // all three boots together need well under 2000 cycles
    initial
    begin
        #100000;
        err_total = err_total + 1;
        final_report;
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        test_compat;
        test_loop;
        test_low;
        final_report;
    end
endmodule
